/* include/ictc_map.svh */
// ictc_map.svh: offsets, field positions and timing counts of the instruction core
// assumes: included by the core only, not by the package; definitions only
`ifndef ICTC_MAP_SVH
`define ICTC_MAP_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define ICTC_CLOCKS_PER_CYCLE 4
`define ICTC_PHASE_LAST       2'h3
// ----------------------------------------
// instruction word fields (16-bit word)
// ----------------------------------------
`define ICTC_OP_MSB   15
`define ICTC_OP_LSB   11
`define ICTC_BIT_MSB  10
`define ICTC_BIT_LSB  8
`define ICTC_ADDR_MSB 10
`define ICTC_ADDR_LSB 0
`define ICTC_DM_MSB   7
`define ICTC_DM_LSB   0
// ----------------------------------------
// special data memory locations and resets
// ----------------------------------------
`define ICTC_PC_LOW_ADDR  8'h0002
`define ICTC_ACC_RESET    8'h0000
`define ICTC_PC_RESET     11'h0000
`define ICTC_NOP_WORD     16'h0000
`endif

/* include/ictc_pkg.sv */
// ictc_pkg.sv: types of the instruction core
// assumes: nothing beyond the map header
package ictc_pkg;
   // ----------------------------------------
   // operation codes, bits 15..11
   // ----------------------------------------
   typedef enum logic [4:0] {
      OP_NOP    = 5'h00, OP_MOV_A_M = 5'h01, OP_MOV_M_A = 5'h02, OP_MOV_A_X = 5'h03,
      OP_ADD_M  = 5'h04, OP_ADC_M   = 5'h05, OP_SUB_M   = 5'h06, OP_SBC_M   = 5'h07,
      OP_ADD_X  = 5'h08, OP_SUB_X   = 5'h09, OP_AND_M   = 5'h0a, OP_OR_M    = 5'h0b,
      OP_XOR_M  = 5'h0c, OP_AND_X   = 5'h0d, OP_INV_M   = 5'h0e, OP_INV_A   = 5'h0f,
      OP_INC_M  = 5'h10, OP_INC_A   = 5'h11, OP_DEC_M   = 5'h12, OP_DEC_A   = 5'h13,
      OP_RR     = 5'h14, OP_RL      = 5'h15, OP_RRC     = 5'h16, OP_RLC     = 5'h17,
      OP_SZ     = 5'h18, OP_SNZ     = 5'h19, OP_SZ_BIT  = 5'h1a, OP_BSET    = 5'h1b,
      OP_BCLR   = 5'h1c, OP_JUMP    = 5'h1d, OP_CALL    = 5'h1e, OP_MISC    = 5'h1f
   } ictc_op_e;
   // misc sub-codes in bits 2..0
   typedef enum logic [2:0] {
      SUB_RET = 3'h0, SUB_INTERRUPT_EXIT_OP = 3'h1, SUB_TBL = 3'h2, SUB_HALT = 3'h3, SUB_WDT = 3'h4
   } ictc_sub_e;
   // cycle state, one-hot
   typedef enum logic [2:0] {
      ST_EXEC = 3'b001, ST_FLUSH = 3'b010, ST_HALT = 3'b100
   } ictc_state_e;
endpackage : ictc_pkg

/* hdl/ictc_core.sv */
// ictc_core.sv: 8-bit instruction core, four clocks to one instruction cycle
// assumes: program memory and data memory answer combinationally to the addresses
// Notes on behaviour
// RULE_01: instruction cycle is four system clocks
// RULE_02: ordinary instructions take one cycle
// RULE_03: jump, call, returns, table read take two
// RULE_04: writing program counter low adds a cycle
// RULE_05: taken skip discards next, uses two
// RULE_06: carry flags add overflow, subtract borrow
// RULE_07: increment/decrement by one, memory or accumulator
// RULE_08: logic ops set zero flag on zero
// RULE_09: rotate one bit, through-carry via carry
// RULE_10: call saves return, exit resumes, jump none
// RULE_11: conditional branch tests byte or bit
// RULE_12: bit set/clear changes only selected bit
// RULE_13: table read fetches program words to registers; the core keeps only the low byte of the word, in tbl_q
// RULE_14: halt enters power-down; watchdog service op
// RULE_15: memory ops go through accumulator
// RULE_16: direct addressing reaches sector zero only
// RULE_17: add updates zero,carry,aux,overflow,signed flags
// RULE_18: extra cycle fetches nothing, pipeline flushed; the core still fetches the table word or the new counter's word in it
`timescale 1ns/100ps
`include "ictc_map.svh"
module ictc_core #(
   parameter int STACK_DEPTH = 8,
   parameter int PC_WIDTH    = 11
) (
   // clock and reset
   input  wire logic                i_clock,
   input  wire logic                i_reset,
   // program memory
   input  wire logic [15:0]         i_prog_word,
   output logic      [PC_WIDTH-1:0] o_prog_addr,
   // data memory, sector 0
   input  wire logic [7:0]          i_data_rd,
   output logic      [7:0]          o_data_addr,
   output logic      [7:0]          o_data_wr,
   output logic                     o_data_we,
   output logic      [1:0]          o_data_sector,
   // status
   output logic      [7:0]          o_accumulator_register,
   output logic      [5:0]          o_flags,
   output logic      [7:0]          o_table_data,
   output logic                     o_power_down,
   output logic                     o_watchdog_clear,
   output logic                     o_cycle_end
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [1:0]              phase_q;       // clock within instruction cycle
   ictc_pkg::ictc_state_e   state_q;       // exec, flush or halted
   logic [PC_WIDTH-1:0]     pc_q;          // program counter
   logic [7:0]              acc_q;         // accumulator
   logic                    z_q, c_q, ac_q, ov_q, sc_q, cz_q; // flags
   logic [PC_WIDTH-1:0]     stack_q [STACK_DEPTH];  // return addresses
   logic [$clog2(STACK_DEPTH)-1:0] sp_q;   // stack pointer
   logic [7:0]              tbl_q;         // table read result
   logic [7:0]              wdata_q;       // data write register
   logic                    we_q, wdt_q, end_q;
   logic [7:0]              daddr_q;
   logic [PC_WIDTH-1:0]     paddr_q;
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire ictc_pkg::ictc_op_e  op   = ictc_pkg::ictc_op_e'(i_prog_word[`ICTC_OP_MSB:`ICTC_OP_LSB]);
   wire ictc_pkg::ictc_sub_e sub  = ictc_pkg::ictc_sub_e'(i_prog_word[2:0]);
   wire logic [7:0]  imm          = i_prog_word[`ICTC_DM_MSB:`ICTC_DM_LSB];
   wire logic [2:0]  bsel         = i_prog_word[`ICTC_BIT_MSB:`ICTC_BIT_LSB];
   wire logic [PC_WIDTH-1:0] target = i_prog_word[PC_WIDTH-1:0];
   wire logic [7:0]  m            = i_data_rd;
   wire logic        is_misc      = (op == ictc_pkg::OP_MISC);
   wire logic [PC_WIDTH-1:0] pc_next = pc_q + PC_WIDTH'(1);
   wire logic [PC_WIDTH-1:0] stack_top = stack_q[sp_q - 1'b1];

   // ----------------------------------------
   // arithmetic unit
   // ----------------------------------------
   wire logic       is_sub  = (op == ictc_pkg::OP_SUB_M) || (op == ictc_pkg::OP_SBC_M) || (op == ictc_pkg::OP_SUB_X);
   wire logic       use_cin = (op == ictc_pkg::OP_ADC_M) || (op == ictc_pkg::OP_SBC_M);
   wire logic [7:0] src     = ((op == ictc_pkg::OP_ADD_X) || (op == ictc_pkg::OP_SUB_X)) ? imm : m; // RULE_15
   wire logic [7:0] opnd    = is_sub ? ~src : src;
   wire logic       cin     = use_cin ? c_q : is_sub;
   // 9-bit sum: bit 8 is carry out, for subtract it is "no borrow"
   wire logic [8:0] sum     = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, cin}; // RULE_06
   wire logic [4:0] nib     = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
   wire logic       ovf     = (acc_q[7] == opnd[7]) && (sum[7] != acc_q[7]);
   wire logic       is_arith = (op >= ictc_pkg::OP_ADD_M && op <= ictc_pkg::OP_SUB_X);

   // ----------------------------------------
   // result selection
   // ----------------------------------------
   logic [7:0] res;
   logic       res_c;
   always_comb begin
      res   = acc_q;
      res_c = c_q;
      unique case (op)
         ictc_pkg::OP_MOV_A_M: res = m;
         ictc_pkg::OP_MOV_A_X: res = imm;
         ictc_pkg::OP_AND_M:   res = acc_q & m;                        // RULE_08
         ictc_pkg::OP_OR_M:    res = acc_q | m;
         ictc_pkg::OP_XOR_M:   res = acc_q ^ m;
         ictc_pkg::OP_AND_X:   res = acc_q & imm;
         ictc_pkg::OP_INV_M, ictc_pkg::OP_INV_A: res = ~m;
         ictc_pkg::OP_INC_M, ictc_pkg::OP_INC_A: res = m + 8'h01;      // RULE_07
         ictc_pkg::OP_DEC_M, ictc_pkg::OP_DEC_A: res = m - 8'h01;
         ictc_pkg::OP_RR:      res = {m[0], m[7:1]};                   // RULE_09
         ictc_pkg::OP_RL:      res = {m[6:0], m[7]};
         ictc_pkg::OP_RRC: begin
            res   = {c_q, m[7:1]};
            res_c = m[0];
         end
         ictc_pkg::OP_RLC: begin
            res   = {m[6:0], c_q};
            res_c = m[7];
         end
         ictc_pkg::OP_BSET:    res = m | (8'h01 << bsel);              // RULE_12
         ictc_pkg::OP_BCLR:    res = m & ~(8'h01 << bsel);
         default: begin
            if (is_arith) begin
               res   = sum[7:0];
               res_c = sum[8];
            end
         end
      endcase
   end

   // ----------------------------------------
   // destination, flag and timing decode
   // ----------------------------------------
   wire logic to_mem = (op == ictc_pkg::OP_MOV_M_A) || (op == ictc_pkg::OP_INV_M) || (op == ictc_pkg::OP_INC_M) ||
                       (op == ictc_pkg::OP_DEC_M) || (op == ictc_pkg::OP_RR) || (op == ictc_pkg::OP_RL) ||
                       (op == ictc_pkg::OP_RRC) || (op == ictc_pkg::OP_RLC) || (op == ictc_pkg::OP_BSET) ||
                       (op == ictc_pkg::OP_BCLR);
   wire logic to_acc = !to_mem && (op != ictc_pkg::OP_NOP) && (op < ictc_pkg::OP_SZ);
   wire logic [7:0] mem_val = (op == ictc_pkg::OP_MOV_M_A) ? acc_q : res;
   wire logic zflag_op = is_arith || (op >= ictc_pkg::OP_AND_M && op <= ictc_pkg::OP_DEC_A);
   // skip conditions on the addressed byte or bit
   wire logic skip_take = ((op == ictc_pkg::OP_SZ) && (m == 8'h00)) ||      // RULE_11
                          ((op == ictc_pkg::OP_SNZ) && (m != 8'h00)) ||
                          ((op == ictc_pkg::OP_SZ_BIT) && !m[bsel]);
   wire logic pcl_write = to_mem && (imm == `ICTC_PC_LOW_ADDR);            // RULE_04
   wire logic do_ret  = is_misc && ((sub == ictc_pkg::SUB_RET) || (sub == ictc_pkg::SUB_INTERRUPT_EXIT_OP));
   wire logic do_tbl  = is_misc && (sub == ictc_pkg::SUB_TBL);
   wire logic do_halt = is_misc && (sub == ictc_pkg::SUB_HALT);
   wire logic do_wdt  = is_misc && (sub == ictc_pkg::SUB_WDT);
   wire logic two_cycle = (op == ictc_pkg::OP_JUMP) || (op == ictc_pkg::OP_CALL) || do_ret || do_tbl || // RULE_03
                          pcl_write || skip_take;                                                   // RULE_05
   // program counter for the instruction after this one
   wire logic [PC_WIDTH-1:0] pc_new =
      ((op == ictc_pkg::OP_JUMP) || (op == ictc_pkg::OP_CALL)) ? target :
      do_ret    ? stack_top :                                              // RULE_10
      pcl_write ? {pc_q[PC_WIDTH-1:8], mem_val} :
      skip_take ? pc_q + PC_WIDTH'(2) : pc_next;
   wire logic last_clk = (phase_q == `ICTC_PHASE_LAST);
   wire logic exec_now = last_clk && (state_q == ictc_pkg::ST_EXEC);

   // ----------------------------------------
   // phase counter: four clocks per cycle
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) phase_q <= 2'h0;
      else phase_q <= phase_q + 2'h1;                                     // RULE_01
   end

   // ----------------------------------------
   // cycle sequencer
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         state_q <= ictc_pkg::ST_EXEC;
         pc_q    <= `ICTC_PC_RESET;
      end else if (last_clk) begin
         unique case (state_q)
            ictc_pkg::ST_EXEC: begin
               pc_q <= pc_new;
               if (do_halt) state_q <= ictc_pkg::ST_HALT;                 // RULE_14
               else if (two_cycle) state_q <= ictc_pkg::ST_FLUSH;         // RULE_02
            end
            // flush cycle: the fetched word is not executed; after a table read its low byte is kept in tbl_q
            ictc_pkg::ST_FLUSH: state_q <= ictc_pkg::ST_EXEC;             // RULE_18
            ictc_pkg::ST_HALT:  state_q <= ictc_pkg::ST_HALT;
         endcase
      end
   end

   // ----------------------------------------
   // accumulator and flags
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         acc_q <= `ICTC_ACC_RESET;
         {z_q, c_q, ac_q, ov_q, sc_q, cz_q} <= 6'h00;
      end else if (exec_now) begin
         if (to_acc) acc_q <= res;                                        // RULE_15
         if ((op == ictc_pkg::OP_SZ) || (op == ictc_pkg::OP_SNZ)) acc_q <= acc_q;
         if (zflag_op) z_q <= (res == 8'h00);                             // RULE_08
         if (is_arith || (op == ictc_pkg::OP_RRC) || (op == ictc_pkg::OP_RLC)) c_q <= res_c;
         if (is_arith) begin                                              // RULE_17
            ac_q <= nib[4];
            ov_q <= ovf;
            sc_q <= sum[7] ^ ovf;
            cz_q <= sum[8] & (sum[7:0] == 8'h00);
         end
      end
   end

   // ----------------------------------------
   // return stack
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) sp_q <= '0;
      else if (exec_now && (op == ictc_pkg::OP_CALL)) begin
         stack_q[sp_q] <= pc_next;                                        // RULE_10
         sp_q          <= sp_q + 1'b1;
      end else if (exec_now && do_ret) sp_q <= sp_q - 1'b1;
   end

   // ----------------------------------------
   // memory strobes, table read and service outputs
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         we_q    <= 1'b0;
         wdata_q <= 8'h00;
         tbl_q   <= 8'h00;
         wdt_q   <= 1'b0;
         end_q   <= 1'b0;
         daddr_q <= 8'h00;
         paddr_q <= `ICTC_PC_RESET;
      end else begin
         we_q    <= exec_now && to_mem;                                   // RULE_12
         wdata_q <= mem_val;
         daddr_q <= imm;                                                  // RULE_16
         wdt_q   <= exec_now && do_wdt;                                   // RULE_14
         end_q   <= last_clk;
         // table read: second cycle fetches table word at accumulator address
         // flush cycles after anything but a table read, and halt cycles, fetch at the settled counter, never one word ahead
         paddr_q <= (exec_now && do_tbl) ? {{(PC_WIDTH-8){1'b0}}, acc_q} :
                    exec_now ? pc_new : (last_clk ? pc_q : paddr_q);            // RULE_18
         if (state_q == ictc_pkg::ST_FLUSH && phase_q == 2'h1 && paddr_q != pc_q)
            tbl_q <= i_prog_word[7:0];                                    // RULE_13
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign o_prog_addr            = paddr_q;
   assign o_data_addr            = daddr_q;
   assign o_data_wr              = wdata_q;
   assign o_data_we              = we_q;
   assign o_data_sector          = 2'h0;
   assign o_accumulator_register = acc_q;
   assign o_flags                = {cz_q, sc_q, ov_q, ac_q, c_q, z_q};
   assign o_table_data           = tbl_q;
   assign o_power_down           = state_q[2];  // one-hot halt bit
   assign o_watchdog_clear       = wdt_q;
   assign o_cycle_end            = end_q;
endmodule : ictc_core

/* verification/ictc_core_sva.sv */
// ictc_core_sva.sv: timing and power-down checks of the instruction core
// assumes: bound to ictc_core from the testbench top file, one clock domain
`timescale 1ns/100ps
module ictc_core_sva #(
   parameter int PC_WIDTH = 11
) (
   // clock and reset
   input wire logic                i_clock,
   input wire logic                i_reset,
   // program and data memory
   input wire logic [15:0]         i_prog_word,
   input wire logic [PC_WIDTH-1:0] o_prog_addr,
   input wire logic [7:0]          i_data_rd,
   input wire logic [7:0]          o_data_addr,
   input wire logic [7:0]          o_data_wr,
   input wire logic                o_data_we,
   input wire logic [1:0]          o_data_sector,
   // status
   input wire logic [7:0]          o_accumulator_register,
   input wire logic [5:0]          o_flags,
   input wire logic [7:0]          o_table_data,
   input wire logic                o_power_down,
   input wire logic                o_watchdog_clear,
   input wire logic                o_cycle_end
);
   // -----------------------------------
   // clocking and sequences
   // -----------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   // three quiet clocks, then the next cycle end
   sequence s_end_gap;
      !o_cycle_end [*3] ##1 o_cycle_end;
   endsequence
   // -----------------------------------
   // assertions
   // -----------------------------------
   a_cycle_four_clocks: assert property (o_cycle_end |=> s_end_gap)
      else $error("cycle end not every fourth clock");
   a_pc_one_step: assert property ($changed(o_prog_addr) |=> $stable(o_prog_addr) [*3])
      else $error("program address moved twice in one cycle");
   a_acc_one_step: assert property ($changed(o_accumulator_register) |=> $stable(o_accumulator_register) [*3])
      else $error("accumulator changed twice in one cycle");
   a_write_pulse: assert property (o_data_we |=> !o_data_we [*3])
      else $error("data write strobe too long or too close");
   a_wdt_pulse: assert property (o_watchdog_clear |=> !o_watchdog_clear [*3])
      else $error("watchdog pulse too long or too close");
   a_sector_zero: assert property (o_data_sector == 2'h0)
      else $error("direct access left sector zero");
   a_halt_holds: assert property (o_power_down |=> o_power_down && $stable(o_prog_addr))
      else $error("power down left or program moved");
   a_halt_quiet: assert property (o_power_down |-> !o_data_we && !o_watchdog_clear)
      else $error("activity while powered down");
endmodule : ictc_core_sva

/* verification/testbench.sv */
// testbench.sv: directed scenarios for the instruction core
// assumes: bench holds program and data memory, answers one clock late
`timescale 1ns/100ps
module testbench;
   // -----------------------------------
   // signals
   // -----------------------------------
   logic        i_clock;
   logic        i_reset;
   logic [15:0] i_prog_word;
   logic [7:0]  i_data_rd;
   logic [10:0] o_prog_addr;
   logic [7:0]  o_data_addr;
   logic [7:0]  o_data_wr;
   logic        o_data_we;
   logic [1:0]  o_data_sector;
   logic [7:0]  o_accumulator_register;
   logic [5:0]  o_flags;
   logic [7:0]  o_table_data;
   logic        o_power_down;
   logic        o_watchdog_clear;
   logic        o_cycle_end;
   logic [15:0] prog [0:2047];  // program memory
   logic [7:0]  dmem [0:255];   // data memory, sector 0
   logic [9:0]  wdt_seen;       // watchdog pulses counted
   int          bad_count;
   int          checks_done;
   // -----------------------------------
   // design and clock
   // -----------------------------------
   ictc_core i_ictc_core (.i_clock(i_clock), .i_reset(i_reset), .i_prog_word(i_prog_word),
      .o_prog_addr(o_prog_addr), .i_data_rd(i_data_rd), .o_data_addr(o_data_addr), .o_data_wr(o_data_wr),
      .o_data_we(o_data_we), .o_data_sector(o_data_sector), .o_accumulator_register(o_accumulator_register),
      .o_flags(o_flags), .o_table_data(o_table_data), .o_power_down(o_power_down),
      .o_watchdog_clear(o_watchdog_clear), .o_cycle_end(o_cycle_end));
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   // memories answer one clock late, which the four-clock cycle absorbs
   always @(posedge i_clock) begin
      i_prog_word <= prog[o_prog_addr];
      i_data_rd   <= dmem[i_prog_word[7:0]];
      if (o_data_we === 1'b1) dmem[o_data_addr] <= o_data_wr;
      if (o_watchdog_clear === 1'b1) wdt_seen <= wdt_seen + 10'h001;
   end
   // -----------------------------------
   // helpers
   // -----------------------------------
   function automatic logic [15:0] w(input logic [4:0] op, input logic [10:0] f);
      return {op, f};
   endfunction : w
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic clr();
      for (int k = 0; k < 2048; k++) prog[k] = 16'h0000;
      for (int k = 0; k < 256; k++) dmem[k] = 8'h00;
      wdt_seen = 10'h000;
   endtask : clr
   task automatic rst();
      @(posedge i_clock);
      i_reset <= 1'b1;
      repeat (4) @(posedge i_clock);
      i_reset <= 1'b0;
   endtask : rst
   // n instruction cycles of four clocks each
   task automatic step(input int n);
      repeat (4 * n) @(posedge i_clock);
      #1;
   endtask : step
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   // -----------------------------------
   // scenarios
   // -----------------------------------
   task automatic test_call();
      clr();
      prog[1] = w(ictc_pkg::OP_CALL, 11'h008);
      prog[2] = w(ictc_pkg::OP_ADD_X, 11'h001);
      prog[3] = w(ictc_pkg::OP_MISC, {8'h00, ictc_pkg::SUB_HALT});
      prog[8] = w(ictc_pkg::OP_ADD_X, 11'h010);
      prog[9] = w(ictc_pkg::OP_MISC, {8'h00, ictc_pkg::SUB_RET});
      rst();
      step(3);
      chk({o_flags[1:0], o_accumulator_register}, 10'h000);
      step(1);
      chk({o_flags[1:0], o_accumulator_register}, 10'h010);
      step(2);
      chk({o_flags[1:0], o_accumulator_register}, 10'h010);
      step(1);
      chk({o_flags[1:0], o_accumulator_register}, 10'h011);
      chk({9'h000, o_power_down}, 10'h000);
      step(1);
      chk({9'h000, o_power_down}, 10'h001);
      $display("test_call done");
   endtask : test_call
   task automatic test_arith();
      clr();
      prog[0] = w(ictc_pkg::OP_MOV_A_X, 11'h0ff);
      prog[1] = w(ictc_pkg::OP_ADD_X, 11'h001);
      prog[2] = w(ictc_pkg::OP_SUB_X, 11'h001);
      prog[3] = w(ictc_pkg::OP_AND_X, 11'h000);
      rst();
      step(2);
      chk({o_flags[1:0], o_accumulator_register}, 10'h300);
      chk({4'h0, o_flags}, 10'h027);
      step(1);
      chk({o_flags[1:0], o_accumulator_register}, 10'h0ff);
      step(1);
      chk({o_flags[1:0], o_accumulator_register}, 10'h100);
      $display("test_arith done");
   endtask : test_arith
   task automatic test_bits();
      clr();
      dmem[8'h20] = 8'h81;
      prog[0] = w(ictc_pkg::OP_BSET, 11'h120);
      prog[1] = w(ictc_pkg::OP_MOV_A_M, 11'h020);
      prog[2] = w(ictc_pkg::OP_RRC, 11'h020);
      prog[3] = w(ictc_pkg::OP_MOV_A_M, 11'h020);
      prog[4] = w(ictc_pkg::OP_DEC_A, 11'h020);
      prog[5] = w(ictc_pkg::OP_RLC, 11'h020);
      prog[6] = w(ictc_pkg::OP_BCLR, 11'h720);
      prog[7] = w(ictc_pkg::OP_INC_A, 11'h020);
      rst();
      step(2);
      chk({o_flags[1:0], o_accumulator_register}, 10'h083);
      step(2);
      chk({o_flags[1:0], o_accumulator_register}, 10'h241);
      step(1);
      chk({o_flags[1:0], o_accumulator_register}, 10'h240);
      step(3);
      chk({o_flags[1:0], o_accumulator_register}, 10'h004);
      chk({2'b00, dmem[8'h20]}, 10'h003);
      $display("test_bits done");
   endtask : test_bits
   task automatic test_skip();
      clr();
      prog[0]     = w(ictc_pkg::OP_SZ, 11'h030);
      prog[1]     = w(ictc_pkg::OP_MOV_A_X, 11'h0ee);
      prog[2]     = w(ictc_pkg::OP_MOV_A_X, 11'h05a);
      prog[3]     = w(ictc_pkg::OP_SNZ, 11'h030);
      prog[4]     = w(ictc_pkg::OP_ADD_X, 11'h001);
      prog[5]     = w(ictc_pkg::OP_MISC, {8'h00, ictc_pkg::SUB_WDT});
      prog[6]     = w(ictc_pkg::OP_MOV_M_A, 11'h002);
      prog[11'h5b] = w(ictc_pkg::OP_MISC, {8'h00, ictc_pkg::SUB_HALT});
      rst();
      step(2);
      chk({o_flags[1:0], o_accumulator_register}, 10'h000);
      step(3);
      chk({o_flags[1:0], o_accumulator_register}, 10'h05b);
      step(3);
      chk({9'h000, o_power_down}, 10'h000);
      step(1);
      chk({9'h000, o_power_down}, 10'h001);
      chk(wdt_seen, 10'h001);
      $display("test_skip done");
   endtask : test_skip
   task automatic test_table();
      clr();
      prog[0]      = w(ictc_pkg::OP_MOV_A_X, 11'h040);
      prog[1]      = w(ictc_pkg::OP_MISC, {8'h00, ictc_pkg::SUB_TBL});
      prog[2]      = w(ictc_pkg::OP_ADD_X, 11'h001);
      prog[11'h40] = 16'hbeef;
      rst();
      step(3);
      chk({2'b00, o_table_data}, 10'h0ef);
      chk({o_flags[1:0], o_accumulator_register}, 10'h040);
      step(1);
      chk({o_flags[1:0], o_accumulator_register}, 10'h041);
      $display("test_table done");
   endtask : test_table
   // -----------------------------------
   // main sequence and hang limit
   // -----------------------------------
   initial begin
      i_reset     = 1'b1;
      i_prog_word = 16'h0000;
      i_data_rd   = 8'h00;
      bad_count   = 0;
      checks_done = 0;
      test_call();
      test_arith();
      test_bits();
      test_skip();
      test_table();
      conclude();
   end
   initial begin
      #2000000;
      bad_count++;
      conclude();
   end
endmodule : testbench
bind ictc_core ictc_core_sva #(.PC_WIDTH(PC_WIDTH)) i_ictc_core_sva (.i_clock(i_clock), .i_reset(i_reset),
   .i_prog_word(i_prog_word), .o_prog_addr(o_prog_addr), .i_data_rd(i_data_rd), .o_data_addr(o_data_addr),
   .o_data_wr(o_data_wr), .o_data_we(o_data_we), .o_data_sector(o_data_sector),
   .o_accumulator_register(o_accumulator_register), .o_flags(o_flags), .o_table_data(o_table_data),
   .o_power_down(o_power_down), .o_watchdog_clear(o_watchdog_clear), .o_cycle_end(o_cycle_end));
